// *** include/ahrs_pkg.sv ***
// constants and types shared by the status word decoder and its top level
// assumes 32-bit ARINC words stored with word bit 1 at index 0
package ahrs_pkg;
  // received label byte of the status word (octal 270)
  localparam logic [7:0] STATUS_LABEL = 8'hb8;
  localparam int unsigned LABEL_W     = 8;
  // word bit n sits at index n-1
  localparam int unsigned IDX_ALIGN    = 10;
  localparam int unsigned IDX_BIT12    = 11;
  localparam int unsigned IDX_MODE_LSB = 12;
  localparam int unsigned IDX_HDG      = 13;
  localparam int unsigned IDX_ATT      = 14;
  localparam int unsigned IDX_MODE_MSB = 15;
  localparam int unsigned IDX_HEALTH   = 18;
  localparam logic [3:0] MODE_CODE_STANDBY  = 4'h6;
  localparam logic [3:0] MODE_CODE_SLAVED   = 4'h0;
  localparam logic [3:0] MODE_CODE_FREE     = 4'h4;
  localparam logic [3:0] MODE_CODE_COMPASS  = 4'h2;
  localparam logic [3:0] MODE_CODE_CAL      = 4'h8;
  localparam logic [3:0] MODE_CODE_HARMONIZ = 4'h1;
  typedef enum logic [1:0] {profile_a, profile_b, profile_c} profile_t;
  localparam logic [1:0] PROFILE_RSVD = 2'h3;
  typedef enum logic [1:0] {src_none, src_429_low, src_429_high, src_other} hdg_src_t;
  typedef enum logic [2:0] {
    mode_standby, mode_slaved, mode_free_gyro, mode_compass,
    mode_compass_cal, software_alignment_harmonizing, mode_unknown
  } op_mode_t;
  // register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_WORD   = 8'h08;
  localparam logic [7:0] ADDR_ISTAT  = 8'h0c;
  localparam logic [7:0] ADDR_IMASK  = 8'h10;
  localparam logic [7:0] ADDR_COUNT  = 8'h14;
  localparam int unsigned CTRL_PROF_LSB = 0;
  localparam int unsigned CTRL_SRC_LSB  = 2;
  localparam int unsigned ST_VALID = 0, ST_ALIGN = 1, ST_SLAVED = 2, ST_FREE = 3;
  localparam int unsigned ST_ATT_INV = 4, ST_ATT_ONLY = 5, ST_FES = 6, ST_FAIL = 7;
  localparam int unsigned ST_UNKNOWN = 8, ST_MODE_LSB = 12, ST_FIELD_LSB = 16;
  localparam int unsigned EVT_WORD = 0, EVT_ALIGN = 1, EVT_SLAVE = 2, EVT_ATT = 3;
  localparam int unsigned EVT_MODE = 4, EVT_UNKNOWN = 5, EVT_FAIL = 6, EVT_N = 7;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam int unsigned HTRANS_ACTIVE = 1;
  localparam logic [31:0] RD_ZERO = 32'h0;

  function automatic op_mode_t mode_lookup(input logic [3:0] f);
    case (f)
      MODE_CODE_STANDBY:  mode_lookup = mode_standby;
      MODE_CODE_SLAVED:   mode_lookup = mode_slaved;
      MODE_CODE_FREE:     mode_lookup = mode_free_gyro;
      MODE_CODE_COMPASS:  mode_lookup = mode_compass;
      MODE_CODE_CAL:      mode_lookup = mode_compass_cal;
      MODE_CODE_HARMONIZ: mode_lookup = software_alignment_harmonizing;
      default:            mode_lookup = mode_unknown;
    endcase
  endfunction

  function automatic logic is_arinc_src(input hdg_src_t s);
    is_arinc_src = (s == src_429_low) || (s == src_429_high);
  endfunction
endpackage

// *** include/ind_if.sv ***
// carries one status word and its decoded indications between top and decoder
// assumes both ends on the same clock; the decoder side is purely combinational
`timescale 1ns/1ps
`default_nettype none
interface ind_if;
  import ahrs_pkg::*;
  logic [31:0] word;
  profile_t    profile;
  logic        aligning;
  logic        slaved;
  logic        free_gyro;
  logic        att_invalid;
  logic        att_only;
  logic        fast_erect;
  logic        fail;
  logic        unknown;
  logic [3:0]  field;
  op_mode_t    mode;
  modport dec (input word, profile,
               output aligning, slaved, free_gyro, att_invalid, att_only,
               fast_erect, fail, unknown, field, mode);
  modport top (output word, profile,
               input aligning, slaved, free_gyro, att_invalid, att_only,
               fast_erect, fail, unknown, field, mode);
endinterface
`default_nettype wire

// *** hw/event_flags.sv ***
// sticky event flags with mask and one level interrupt
// assumes clr is a one-cycle pulse from a status read on the same clock
`timescale 1ns/1ps
`default_nettype none
module event_flags #(
  parameter int unsigned N = 4
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [N-1:0] evt,
  input  wire logic         clr,
  input  wire logic [N-1:0] mask,
  output logic      [N-1:0] stat,
  output logic              irq
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_flag
      // an event in the clearing cycle survives the clear
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          stat[i] <= 1'b0;
        end else begin
          stat[i] <= evt[i] | (stat[i] & ~clr);
        end
      end
    end
  endgenerate
  assign irq = |(stat & mask);
endmodule
`default_nettype wire

// *** hw/status_decoder.sv ***
// combinational decode of one status word under the selected profile
// assumes the top level latches the outputs only for accepted words
`timescale 1ns/1ps
`default_nettype none
module status_decoder
  import ahrs_pkg::*;
(
  ind_if.dec d
);
  wire logic     is_b;
  wire logic     is_c;
  wire logic [3:0] raw_field;
  wire op_mode_t looked;
  assign is_b = d.profile == profile_b;
  assign is_c = d.profile == profile_c;
  assign raw_field = d.word[IDX_MODE_MSB:IDX_MODE_LSB];
  assign looked = mode_lookup(raw_field);
  assign d.aligning = d.word[IDX_ALIGN];
  // in the mode-field profile heading state comes from the mode code only
  assign d.slaved = is_c ? (looked == mode_slaved) : d.word[IDX_HDG];
  assign d.free_gyro = is_c ? (looked == mode_free_gyro) : !d.word[IDX_HDG];
  assign d.att_invalid = !is_c && d.word[IDX_ATT];
  assign d.att_only = is_b && d.word[IDX_BIT12];
  assign d.fast_erect = is_c && d.word[IDX_BIT12];
  assign d.field = is_c ? raw_field : 4'h0;
  assign d.mode = is_c ? looked : mode_unknown;
  assign d.unknown = is_c && (looked == mode_unknown);
  assign d.fail = is_c && d.word[IDX_HEALTH];
endmodule
`default_nettype wire

// *** hw/ahrs_status_word_decoder.sv ***
// top level: AHB-Lite register slave, label filter and indication latches
// assumes rx_word/rx_valid come from an ARINC receiver on hclk
// assumes a single-slave bus so hready equals our hreadyout
`timescale 1ns/1ps
`default_nettype none
module ahrs_status_word_decoder
  import ahrs_pkg::*;
#(
  parameter int unsigned CNT_W = 16,
  parameter logic [7:0]  LABEL = STATUS_LABEL
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic      [31:0] hrdata,
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_valid,
  output logic             status_valid,
  output logic             align_in_progress,
  output logic             heading_slaved,
  output logic             free_gyro_heading,
  output logic             attitude_invalid,
  output logic             attitude_or_navigation_select,
  output logic             fast_erect_indication,
  output logic             health_pass_fail,
  output logic             mode_unknown_flag,
  output logic      [2:0]  op_mode,
  output logic      [3:0]  mode_field,
  output logic             irq
);

  if (CNT_W < 1 || CNT_W > 16) begin : g_bad_cnt
    $error("CNT_W must lie between 1 and 16");
  end

  // ---- bus address phase capture
  logic              dp_valid_q;
  logic              dp_write_q;
  logic              dp_word_q;
  logic [ADDR_W-1:0] dp_addr_q;
  wire logic         take;

  assign take = hsel && htrans[HTRANS_ACTIVE] && hready;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_valid_q <= 1'b0;
      dp_write_q <= 1'b0;
      dp_word_q  <= 1'b0;
      dp_addr_q  <= '0;
    end else if (hready) begin
      dp_valid_q <= take;
      dp_write_q <= hwrite;
      dp_word_q  <= hsize == HSIZE_WORD;
      dp_addr_q  <= haddr[ADDR_W-1:0];
    end
  end

  // never waits, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // narrower writes are ignored rather than merged into the word
  wire logic wr_en;
  wire logic rd_en;
  wire logic wr_ctrl;
  wire logic wr_mask;
  wire logic rd_istat;
  assign wr_en    = dp_valid_q && dp_write_q && dp_word_q;
  assign rd_en    = dp_valid_q && !dp_write_q;
  assign wr_ctrl  = wr_en && dp_addr_q == ADDR_CTRL;
  assign wr_mask  = wr_en && dp_addr_q == ADDR_IMASK;
  assign rd_istat = rd_en && dp_addr_q == ADDR_ISTAT;

  // ---- configuration
  profile_t       prof_q;
  hdg_src_t       src_q;
  logic [EVT_N-1:0] mask_q;
  wire hdg_src_t  new_src;
  wire logic [1:0] new_prof;
  wire logic      prof_ok;

  assign new_src  = hdg_src_t'(hwdata[CTRL_SRC_LSB +: 2]);
  assign new_prof = hwdata[CTRL_PROF_LSB +: 2];
  // a profile write only lands while the new source is an ARINC input
  assign prof_ok  = is_arinc_src(new_src) && new_prof != PROFILE_RSVD;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prof_q <= profile_a;
      src_q  <= src_none;
      mask_q <= '0;
    end else begin
      if (wr_ctrl) begin
        src_q <= new_src;
      end
      if (wr_ctrl && prof_ok) begin
        prof_q <= profile_t'(new_prof);
      end
      if (wr_mask) begin
        mask_q <= hwdata[EVT_N-1:0];
      end
    end
  end

  // ---- word acceptance
  wire logic label_hit;
  wire logic decode_on;
  wire logic accept;
  wire logic ignored;

  assign label_hit = rx_valid && rx_word[LABEL_W-1:0] == LABEL;
  assign decode_on = is_arinc_src(src_q);
  assign accept    = label_hit && decode_on;
  assign ignored   = label_hit && !decode_on;

  ind_if dif ();
  assign dif.word    = rx_word;
  assign dif.profile = prof_q;

  status_decoder u_dec (
    .d (dif.dec)
  );

  // ---- held indications
  logic        valid_q;
  logic        align_q;
  logic        slaved_q;
  logic        free_q;
  logic        att_inv_q;
  logic        att_only_q;
  logic        fes_q;
  logic        fail_q;
  logic        unknown_q;
  op_mode_t    mode_q;
  logic [3:0]  field_q;
  logic [31:0] word_q;

  // indications only move on an accepted word, so a profile change or a
  // source change leaves the last picture standing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      valid_q    <= 1'b0;
      align_q    <= 1'b0;
      slaved_q   <= 1'b0;
      free_q     <= 1'b0;
      att_inv_q  <= 1'b0;
      att_only_q <= 1'b0;
      fes_q      <= 1'b0;
      fail_q     <= 1'b0;
      unknown_q  <= 1'b0;
      mode_q     <= mode_unknown;
      field_q    <= 4'h0;
      word_q     <= 32'h0;
    end else if (accept) begin
      valid_q    <= 1'b1;
      align_q    <= dif.aligning;
      slaved_q   <= dif.slaved;
      free_q     <= dif.free_gyro;
      att_inv_q  <= dif.att_invalid;
      att_only_q <= dif.att_only;
      fes_q      <= dif.fast_erect;
      fail_q     <= dif.fail;
      unknown_q  <= dif.unknown;
      mode_q     <= dif.mode;
      field_q    <= dif.field;
      word_q     <= rx_word;
    end
  end

  assign status_valid                  = valid_q;
  assign align_in_progress             = align_q;
  assign heading_slaved                = slaved_q;
  assign free_gyro_heading             = free_q;
  assign attitude_invalid              = att_inv_q;
  assign attitude_or_navigation_select = att_only_q;
  assign fast_erect_indication         = fes_q;
  assign health_pass_fail              = fail_q;
  assign mode_unknown_flag             = unknown_q;
  assign op_mode                       = mode_q;
  assign mode_field                    = field_q;

  // ---- events
  // change events need a previous word to compare against
  wire logic [EVT_N-1:0] evt;
  assign evt[EVT_WORD]    = accept;
  assign evt[EVT_ALIGN]   = accept && valid_q && dif.aligning != align_q;
  assign evt[EVT_SLAVE]   = accept && valid_q && dif.slaved != slaved_q;
  assign evt[EVT_ATT]     = accept && valid_q && dif.att_invalid != att_inv_q;
  assign evt[EVT_MODE]    = accept && valid_q && dif.mode != mode_q;
  assign evt[EVT_UNKNOWN] = accept && dif.unknown;
  assign evt[EVT_FAIL]    = accept && dif.fail;

  logic [EVT_N-1:0] istat;

  event_flags #(
    .N (EVT_N)
  ) u_flags (
    .clk   (hclk),
    .rst_n (hresetn),
    .evt   (evt),
    .clr   (rd_istat),
    .mask  (mask_q),
    .stat  (istat),
    .irq   (irq)
  );

  // ---- counters, wrapping
  logic [CNT_W-1:0] acc_cnt_q;
  logic [CNT_W-1:0] ign_cnt_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_cnt_q <= '0;
      ign_cnt_q <= '0;
    end else begin
      if (accept) begin
        acc_cnt_q <= acc_cnt_q + 1'b1;
      end
      if (ignored) begin
        ign_cnt_q <= ign_cnt_q + 1'b1;
      end
    end
  end

  // ---- read mux
  wire logic [31:0] ctrl_rd;
  wire logic [31:0] status_rd;
  wire logic [31:0] count_rd;
  wire logic [31:0] sel_rd;

  assign ctrl_rd = (32'(prof_q) << CTRL_PROF_LSB)
                 | (32'(src_q) << CTRL_SRC_LSB);

  assign status_rd = (32'(valid_q) << ST_VALID)
                   | (32'(align_q) << ST_ALIGN)
                   | (32'(slaved_q) << ST_SLAVED)
                   | (32'(free_q) << ST_FREE)
                   | (32'(att_inv_q) << ST_ATT_INV)
                   | (32'(att_only_q) << ST_ATT_ONLY)
                   | (32'(fes_q) << ST_FES)
                   | (32'(fail_q) << ST_FAIL)
                   | (32'(unknown_q) << ST_UNKNOWN)
                   | (32'(mode_q) << ST_MODE_LSB)
                   | (32'(field_q) << ST_FIELD_LSB);

  // ignored count sits in the upper half of the count register
  localparam int unsigned IGN_LSB = 16;
  assign count_rd = (32'(ign_cnt_q) << IGN_LSB) | 32'(acc_cnt_q);

  assign sel_rd = (dp_addr_q == ADDR_CTRL)   ? ctrl_rd
                : (dp_addr_q == ADDR_STATUS) ? status_rd
                : (dp_addr_q == ADDR_WORD)   ? word_q
                : (dp_addr_q == ADDR_ISTAT)  ? 32'(istat)
                : (dp_addr_q == ADDR_IMASK)  ? 32'(mask_q)
                : (dp_addr_q == ADDR_COUNT)  ? count_rd
                : RD_ZERO;

  // data phase reads the live registers, so a write just before is seen
  assign hrdata = rd_en ? sel_rd : RD_ZERO;

endmodule
`default_nettype wire

// *** dv/ahrs_status_word_decoder_assertions.sv ***
// concurrent checks on the indication ports of the status word decoder
// assumes one clock hclk and the asynchronous active-low hresetn
`timescale 1ns/1ps
`default_nettype none
module ahrs_status_word_decoder_assertions
  import ahrs_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic [31:0] rx_word,
  input wire logic        rx_valid,
  input wire logic        status_valid,
  input wire logic        align_in_progress,
  input wire logic        heading_slaved,
  input wire logic        free_gyro_heading,
  input wire logic        attitude_invalid,
  input wire logic        attitude_or_navigation_select,
  input wire logic        fast_erect_indication,
  input wire logic        health_pass_fail,
  input wire logic        mode_unknown_flag,
  input wire logic [2:0]  op_mode,
  input wire logic [3:0]  mode_field
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // profiles a and b leave op_mode unknown without raising the unknown flag
  wire       prof_ab = status_valid && op_mode == mode_unknown && !mode_unknown_flag;
  wire       bit11   = rx_word[IDX_ALIGN];
  wire [3:0] fld     = rx_word[IDX_MODE_MSB:IDX_MODE_LSB];
  sequence align_moved;
    !$stable(align_in_progress);
  endsequence
  sequence field_loaded;
    !$stable(mode_field) && mode_field != 4'h0;
  endsequence
  chk_align_follows: assert property (align_moved |-> $past(rx_valid) && align_in_progress == $past(bit11))
    else $error("alignment flag moved without a matching word");
  chk_hold_between: assert property (!$past(rx_valid) |-> $stable({align_in_progress,
    heading_slaved, free_gyro_heading, attitude_invalid, fast_erect_indication, op_mode, mode_field}))
    else $error("indications changed with no word");
  chk_heading_ab: assert property (prof_ab |-> heading_slaved != free_gyro_heading)
    else $error("heading slaved and free gyro not exclusive");
  chk_ab_quiet: assert property (prof_ab |-> !fast_erect_indication && mode_field == 4'h0)
    else $error("profile c indications seen in a or b");
  chk_c_no_att: assert property (status_valid && !prof_ab |-> !attitude_invalid)
    else $error("attitude flag raised in profile c");
  chk_field_load: assert property (field_loaded |-> mode_field == $past(fld))
    else $error("mode field not taken from bits 16 to 13");
  chk_standby_code: assert property (mode_field == MODE_CODE_STANDBY |-> op_mode == mode_standby)
    else $error("standby code decoded wrongly");
  chk_cal_code: assert property (mode_field == MODE_CODE_CAL |-> op_mode == mode_compass_cal)
    else $error("calibration code decoded wrongly");
  chk_unknown_set: assert property (mode_unknown_flag |-> op_mode == mode_unknown && !heading_slaved)
    else $error("unknown flag with a known mode");
  chk_att_only: assert property (attitude_or_navigation_select |-> prof_ab && !fast_erect_indication)
    else $error("attitude-only mode outside profile b");
  chk_fail_rise: assert property ($rose(health_pass_fail) |-> $past(rx_valid) && $past(rx_word[IDX_HEALTH]))
    else $error("fail raised without bit 19 in a word");
endmodule
bind ahrs_status_word_decoder ahrs_status_word_decoder_assertions chk_i (
  .hclk(hclk), .hresetn(hresetn), .rx_word(rx_word), .rx_valid(rx_valid),
  .status_valid(status_valid), .align_in_progress(align_in_progress),
  .heading_slaved(heading_slaved), .free_gyro_heading(free_gyro_heading),
  .attitude_invalid(attitude_invalid), .health_pass_fail(health_pass_fail),
  .attitude_or_navigation_select(attitude_or_navigation_select),
  .fast_erect_indication(fast_erect_indication), .mode_unknown_flag(mode_unknown_flag),
  .op_mode(op_mode), .mode_field(mode_field));
`default_nettype wire

// *** dv/ahrs_unit_model.sv ***
// heading reference unit as seen through the word receiver: one word per strobe
// assumes the receiver hands over words on hclk with a one-cycle valid
`timescale 1ns/1ps
`default_nettype none
module ahrs_unit_model (
  input  wire logic        hclk,
  output logic      [31:0] rx_word,
  output logic             rx_valid
);
  initial begin
    rx_word  = 32'h0;
    rx_valid = 1'b0;
  end
  task automatic send(input logic [31:0] w);
    @(posedge hclk);
    rx_word  <= w;
    rx_valid <= 1'b1;
    @(posedge hclk);
    rx_valid <= 1'b0;
    // stale data is inverted so it can never pass for the last word
    rx_word  <= ~w;
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the status word decoder
// assumes the unit model drives the word input and the bench masters the bus
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ahrs_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_valid, irq;
  logic [31:0] haddr, hwdata, hrdata, rx_word;
  logic [1:0]  htrans;
  logic [2:0]  hsize, op_mode;
  logic [3:0]  mode_field;
  logic        status_valid, align_in_progress, heading_slaved, free_gyro_heading;
  logic        attitude_invalid, attitude_or_navigation_select, fast_erect_indication;
  logic        health_pass_fail, mode_unknown_flag;
  int          mismatches = 0;
  int          samples_checked = 0;
  localparam logic [31:0] lbl = {24'h0, STATUS_LABEL};
  localparam logic [3:0]  codes [6] = '{MODE_CODE_STANDBY, MODE_CODE_SLAVED, MODE_CODE_FREE,
                                        MODE_CODE_COMPASS, MODE_CODE_CAL, MODE_CODE_HARMONIZ};
  wire [15:0] ind = {op_mode, mode_field, status_valid, align_in_progress, heading_slaved,
                     free_gyro_heading, attitude_invalid, attitude_or_navigation_select,
                     fast_erect_indication, health_pass_fail, mode_unknown_flag};
  ahrs_status_word_decoder ahrs_status_word_decoder_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .rx_word(rx_word),
    .rx_valid(rx_valid), .status_valid(status_valid), .align_in_progress(align_in_progress),
    .heading_slaved(heading_slaved), .free_gyro_heading(free_gyro_heading),
    .attitude_invalid(attitude_invalid), .health_pass_fail(health_pass_fail),
    .attitude_or_navigation_select(attitude_or_navigation_select),
    .fast_erect_indication(fast_erect_indication), .mode_unknown_flag(mode_unknown_flag),
    .op_mode(op_mode), .mode_field(mode_field), .irq(irq));
  ahrs_unit_model ahrs_unit_model_i (.hclk(hclk), .rx_word(rx_word), .rx_valid(rx_valid));
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  function automatic logic [31:0] bn(input int n);
    return 32'h1 << (n - 1);
  endfunction
  function automatic logic [15:0] expect_ind(input int p, input logic [31:0] w);
    logic [3:0] f;
    logic [2:0] m;
    logic       b14;
    f = w[IDX_MODE_MSB:IDX_MODE_LSB];
    b14 = w[IDX_HDG];
    m = mode_unknown;
    for (int i = 0; i < 6; i++) if (f == codes[i]) m = 3'(i);
    if (p == 2) return {m, f, 2'b11 & {1'b1, w[IDX_ALIGN]}, m == mode_slaved,
                        m == mode_free_gyro, 2'b00, w[IDX_BIT12], w[IDX_HEALTH], m == mode_unknown};
    return {3'h6, 4'h0, 1'b1, w[IDX_ALIGN], b14, !b14, w[IDX_ATT], p == 1 && w[IDX_BIT12], 3'b000};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    haddr <= {24'h0, a};
    // no cycle limit here: only the watchdog may end a wait
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask
  task automatic rd_chk(input string s, input logic [7:0] a, input logic [31:0] e, input logic [31:0] k);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(s, e & k, x & k);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic word_chk(input int p, input logic [31:0] w);
    ahrs_unit_model_i.send(w);
    #1;
    chk("indications", {16'h0, expect_ind(p, w)}, {16'h0, ind});
  endtask
  task automatic t_reset;
    chk("reset ind", 32'hc000, {16'h0, ind});
    rd_chk("ctrl", ADDR_CTRL, 32'h0, 32'hf);
    rd_chk("status", ADDR_STATUS, 32'h6000, 32'hffffffff);
    rd_chk("unmapped", 8'h40, 32'h0, 32'hffffffff);
    $display("reset test done");
  endtask
  task automatic t_gate;
    wr(ADDR_CTRL, 32'h2);
    rd_chk("ctrl", ADDR_CTRL, 32'h0, 32'hf);
    ahrs_unit_model_i.send(lbl | bn(11));
    #1;
    chk("gated ind", 32'hc000, {16'h0, ind});
    rd_chk("count", ADDR_COUNT, 32'h00010000, 32'hffffffff);
    wr(ADDR_CTRL, 32'hd);
    rd_chk("ctrl other src", ADDR_CTRL, 32'hc, 32'hf);
    wr(ADDR_CTRL, 32'h7);
    rd_chk("ctrl rsvd prof", ADDR_CTRL, 32'h4, 32'hf);
    $display("source gate test done");
  endtask
  task automatic t_prof_ab;
    wr(ADDR_CTRL, 32'h4);
    word_chk(0, lbl | bn(11) | bn(15));
    word_chk(0, lbl | bn(12) | bn(14));
    ahrs_unit_model_i.send(32'h55 | bn(11));
    #1;
    chk("other label", {16'h0, expect_ind(0, lbl | bn(12) | bn(14))}, {16'h0, ind});
    wr(ADDR_CTRL, 32'h9);
    word_chk(1, lbl | bn(12) | bn(15));
    word_chk(1, lbl | bn(11) | bn(14));
    $display("profile a b test done");
  endtask
  task automatic t_prof_c;
    logic [3:0]  c;
    logic [31:0] w;
    wr(ADDR_CTRL, 32'h6);
    for (int i = 0; i < 8; i++) begin
      c = (i < 6) ? codes[i] : ((i == 6) ? 4'hf : 4'ha);
      w = lbl | ({28'h0, c} << IDX_MODE_LSB) | (i[0] ? bn(12) : 32'h0) | (i[1] ? bn(19) : 32'h0);
      word_chk(2, w | (i[2] ? bn(11) : 32'h0));
    end
    wr(ADDR_CTRL, 32'h4);
    #1;
    chk("profile swap", {16'h0, expect_ind(2, w | bn(11))}, {16'h0, ind});
    rd_chk("word", ADDR_WORD, w | bn(11), 32'hffffffff);
    rd_chk("status c", ADDR_STATUS, 32'h000a61c3, 32'hffffffff);
    rd_chk("count c", ADDR_COUNT, 32'h0001000c, 32'hffffffff);
    $display("profile c test done");
  endtask
  task automatic t_irq;
    rd_chk("istat clear", ADDR_ISTAT, 32'h7f, 32'hffffffff);
    wr(ADDR_IMASK, 32'h1);
    chk("irq idle", 32'h0, {31'h0, irq});
    ahrs_unit_model_i.send(lbl);
    #1;
    chk("irq raised", 32'h1, {31'h0, irq});
    rd_chk("istat word", ADDR_ISTAT, 32'h1, 32'h1);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(ADDR_IMASK, 32'h0);
    ahrs_unit_model_i.send(lbl);
    #1;
    chk("irq masked", 32'h0, {31'h0, irq});
    rd_chk("istat masked", ADDR_ISTAT, 32'h1, 32'h1);
    $display("interrupt test done");
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    // about a hundred cycles of traffic; the margin covers a bus that never answers
    #(5000 * 5);
    mismatches++;
    conclude();
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_gate();
    t_prof_ab();
    t_prof_c();
    t_irq();
    conclude();
  end
endmodule
`default_nettype wire
